// file: rtl/ssp_pkg.sv
package ssp_pkg;

  // ------------------------------------------------------------
  // Configuration port addresses
  // ------------------------------------------------------------
  localparam logic [7:0] CFG_INDEX_HI = 8'h4E;
  localparam logic [7:0] CFG_DATA_HI = 8'h4F;
  localparam logic [7:0] CFG_INDEX_LO = 8'h2E;
  localparam logic [7:0] CFG_DATA_LO = 8'h2F;

  // ------------------------------------------------------------
  // Strap reset values (weak pull-down default)
  // ------------------------------------------------------------
  localparam logic STRAP_RESET_VAL = 1'b0;
  localparam int SYNC_STAGES = 3;

  // ------------------------------------------------------------
  // Strap groups by governing reset
  // ------------------------------------------------------------
  // Host bus reset group
  typedef struct packed {
    logic cfg_port_addr_strap;
    logic postcode_display_strap;
    logic serial_postcode_strap;
    logic serial_c_postcode_strap;
  } ssp_host_s;

  // Main power good group
  typedef struct packed {
    logic clk_rate_strap;
  } ssp_main_s;

  // Standby resume reset group
  typedef struct packed {
    logic test_one_strap;
    logic test_two_strap;
    logic test_zero_strap;
    logic deep_sleep_well_strap;
    logic cpu_power_seq_strap;
  } ssp_stby_s;

  localparam int HOST_W = $bits(ssp_host_s);
  localparam int MAIN_W = $bits(ssp_main_s);
  localparam int STBY_W = $bits(ssp_stby_s);

  // Latch state per group: waiting for reset release, or holding
  typedef enum logic [0:0] {
    SSP_ARMED = 1'b0,
    SSP_HELD = 1'b1
  } ssp_latch_e;

endpackage

// file: rtl/ssp_strap_sampler.sv
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Port-address strap sampled at host bus reset; high 4Eh/4Fh, low 2Eh/2Fh.
// - Clock-rate strap sampled on main power good; high 48MHz, low 24MHz.
// - Post-code display strap sampled at host bus reset; high display, low GPIO.
// - Serial post-code strap sampled at host bus reset, selects its pin function.
// - Second serial post-code strap sampled at host bus reset, selects its pin.
// - Three test-mode straps latched on standby resume reset; board pulls them down.
// - Deep-sleep-well strap latched on standby reset; high deep-sleep pins, low GPIO.
// - CPU power-sequence strap latched on standby reset; high enables sequencing.
// - Host LPC writes may overwrite every latched strap result.
// - Standby straps return to sampled values only on standby resume reset.
// - Main power straps reset to sampled values by main power good.
// - Port-address result restored to sampled value on host bus reset.
// - Main-group pull-downs enabled only during main power-up reset.
// - Test-two and CPU-sequence pull-downs enabled only during standby reset.
// - Post-code display strap also selects the seven-segment pin group function.
// - Deep-sleep-well zero: pin is GPIO bit 53; one: suspend warning output.
module ssp_strap_sampler
  import ssp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Governing resets from other wells, active low except main_power_good
  input wire logic standby_resume_reset_n,
  input wire logic main_power_good,
  input wire logic host_bus_reset_n,
  // Strap pin levels
  input wire ssp_host_s host_strap_pins,
  input wire ssp_main_s main_strap_pins,
  input wire ssp_stby_s stby_strap_pins,
  // Host override writes
  input wire logic host_wr_host,
  input wire ssp_host_s host_wdata_host,
  input wire logic host_wr_main,
  input wire ssp_main_s host_wdata_main,
  input wire logic host_wr_stby,
  input wire ssp_stby_s host_wdata_stby,
  // Latched results
  output ssp_host_s host_straps,
  output ssp_main_s main_straps,
  output ssp_stby_s stby_straps,
  output logic [7:0] cfg_index_port,
  output logic [7:0] cfg_data_port,
  output logic clk_is_48m,
  output logic seven_seg_display_en,
  output logic gpio_port5_bit3_sel,
  output logic dual_rail_suspend_warn_sel,
  // Internal pull-down enables
  output logic main_group_pulldown_en,
  output logic stby_group_pulldown_en
);

  // ------------------------------------------------------------
  // Synchronisers: three stages, change counts when 2nd and 3rd agree
  // ------------------------------------------------------------
  localparam int SYN_W = 3 + HOST_W + MAIN_W + STBY_W;
  // The agree-filter below is written for exactly three stages
  if (SYNC_STAGES != 3) begin : g_sync_depth_check
    $error("ssp: synchroniser depth must be 3");
  end

  logic [SYN_W-1:0] syn1, syn2, syn3, filt;
  logic [SYN_W-1:0] next_syn1, next_syn2, next_syn3, next_filt;
  localparam logic [SYN_W-1:0] SYN_RST = {1'b0, 1'b0, 1'b0, {(SYN_W-3){STRAP_RESET_VAL}}};

  always_comb begin
    next_syn1 = {standby_resume_reset_n, main_power_good, host_bus_reset_n,
                 host_strap_pins, main_strap_pins, stby_strap_pins};
    next_syn2 = syn1;
    next_syn3 = syn2;
    for (int i = 0; i < SYN_W; i++) begin
      next_filt[i] = (syn2[i] == syn3[i]) ? syn3[i] : filt[i];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      syn1 <= SYN_RST;
      syn2 <= SYN_RST;
      syn3 <= SYN_RST;
      filt <= SYN_RST;
    end else begin
      syn1 <= next_syn1;
      syn2 <= next_syn2;
      syn3 <= next_syn3;
      filt <= next_filt;
    end
  end

  logic stby_rst_n, main_pg, host_rst_n;
  ssp_host_s host_pin_f;
  ssp_main_s main_pin_f;
  ssp_stby_s stby_pin_f;
  assign {stby_rst_n, main_pg, host_rst_n, host_pin_f, main_pin_f, stby_pin_f} = filt;

  // ------------------------------------------------------------
  // Strap latches, one group per governing reset
  // ------------------------------------------------------------
  // A group in reset keeps its last value; at release it samples
  // the pin once, then only host writes may change it.
  ssp_latch_e host_st, main_st, stby_st;
  ssp_latch_e next_host_st, next_main_st, next_stby_st;
  ssp_host_s host_q, next_host_q;
  ssp_main_s main_q, next_main_q;
  ssp_stby_s stby_q, next_stby_q;

  always_comb begin
    next_host_st = host_st;
    next_host_q = host_q;
    case (host_st)
      SSP_ARMED: begin
        if (host_rst_n) begin
          next_host_q = host_pin_f;
          next_host_st = SSP_HELD;
        end
      end
      SSP_HELD: begin
        if (!host_rst_n) begin
          next_host_st = SSP_ARMED;
        end else if (host_wr_host) begin
          next_host_q = host_wdata_host;
        end
      end
      default: next_host_st = SSP_ARMED;
    endcase
  end

  always_comb begin
    next_main_st = main_st;
    next_main_q = main_q;
    case (main_st)
      SSP_ARMED: begin
        if (main_pg) begin
          next_main_q = main_pin_f;
          next_main_st = SSP_HELD;
        end
      end
      SSP_HELD: begin
        if (!main_pg) begin
          next_main_st = SSP_ARMED;
        end else if (host_wr_main) begin
          next_main_q = host_wdata_main;
        end
      end
      default: next_main_st = SSP_ARMED;
    endcase
  end

  always_comb begin
    next_stby_st = stby_st;
    next_stby_q = stby_q;
    case (stby_st)
      SSP_ARMED: begin
        if (stby_rst_n) begin
          next_stby_q = stby_pin_f;
          next_stby_st = SSP_HELD;
        end
      end
      SSP_HELD: begin
        if (!stby_rst_n) begin
          next_stby_st = SSP_ARMED;
        end else if (host_wr_stby) begin
          next_stby_q = host_wdata_stby;
        end
      end
      default: next_stby_st = SSP_ARMED;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_st <= SSP_ARMED;
      main_st <= SSP_ARMED;
      stby_st <= SSP_ARMED;
      host_q <= '0;
      main_q <= '0;
      stby_q <= '0;
    end else begin
      host_st <= next_host_st;
      main_st <= next_main_st;
      stby_st <= next_stby_st;
      host_q <= next_host_q;
      main_q <= next_main_q;
      stby_q <= next_stby_q;
    end
  end

  // ------------------------------------------------------------
  // Decoded configuration, all registered
  // ------------------------------------------------------------
  logic [7:0] next_idx, next_dat;
  logic next_48m, next_seg, next_gpio_sel, next_warn, next_main_pd, next_stby_pd;

  always_comb begin
    next_idx = host_q.cfg_port_addr_strap ? CFG_INDEX_HI : CFG_INDEX_LO;
    next_dat = host_q.cfg_port_addr_strap ? CFG_DATA_HI : CFG_DATA_LO;
    next_48m = main_q.clk_rate_strap;
    next_seg = host_q.postcode_display_strap;
    next_gpio_sel = !stby_q.deep_sleep_well_strap;
    next_warn = stby_q.deep_sleep_well_strap;
    // Pulls are on only while the well's power-up reset holds the group
    next_main_pd = !main_pg;
    next_stby_pd = !stby_rst_n;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_straps <= '0;
      main_straps <= '0;
      stby_straps <= '0;
      cfg_index_port <= CFG_INDEX_LO;
      cfg_data_port <= CFG_DATA_LO;
      clk_is_48m <= 1'b0;
      seven_seg_display_en <= 1'b0;
      gpio_port5_bit3_sel <= 1'b1;
      dual_rail_suspend_warn_sel <= 1'b0;
      main_group_pulldown_en <= 1'b1;
      stby_group_pulldown_en <= 1'b1;
    end else begin
      host_straps <= host_q;
      main_straps <= main_q;
      stby_straps <= stby_q;
      cfg_index_port <= next_idx;
      cfg_data_port <= next_dat;
      clk_is_48m <= next_48m;
      seven_seg_display_en <= next_seg;
      gpio_port5_bit3_sel <= next_gpio_sel;
      dual_rail_suspend_warn_sel <= next_warn;
      main_group_pulldown_en <= next_main_pd;
      stby_group_pulldown_en <= next_stby_pd;
    end
  end

endmodule

`default_nettype wire

// file: dv/ssp_strap_sampler_props.sv
`timescale 1ns/1ns
`default_nettype none
module ssp_strap_sampler_props
  import ssp_pkg::*;
(
  // Clock and resets
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic main_power_good,
  input wire logic host_bus_reset_n,
  input wire logic standby_resume_reset_n,
  // Host write
  input wire logic host_wr_host,
  input wire ssp_host_s host_wdata_host,
  // Results
  input wire ssp_host_s host_straps,
  input wire ssp_main_s main_straps,
  input wire ssp_stby_s stby_straps,
  input wire logic [7:0] cfg_index_port,
  input wire logic [7:0] cfg_data_port,
  input wire logic clk_is_48m,
  input wire logic seven_seg_display_en,
  input wire logic gpio_port5_bit3_sel,
  input wire logic dual_rail_suspend_warn_sel,
  input wire logic main_group_pulldown_en,
  input wire logic stby_group_pulldown_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // Decodes follow the latched results, pulls follow the resets, host writes land
  // ----------------------------------------
  chk_index_decode: assert property (
    cfg_index_port == (host_straps.cfg_port_addr_strap ? CFG_INDEX_HI : CFG_INDEX_LO))
    else $error("bad index port");
  chk_data_decode: assert property (
    cfg_data_port == (host_straps.cfg_port_addr_strap ? CFG_DATA_HI : CFG_DATA_LO))
    else $error("bad data port");
  chk_clk_rate: assert property (clk_is_48m == main_straps.clk_rate_strap)
    else $error("bad clock rate");
  chk_seg_sel: assert property (
    seven_seg_display_en == host_straps.postcode_display_strap) else $error("bad seg");
  chk_gpio_sel: assert property (
    gpio_port5_bit3_sel != stby_straps.deep_sleep_well_strap) else $error("bad gpio");
  chk_warn_sel: assert property (
    dual_rail_suspend_warn_sel == stby_straps.deep_sleep_well_strap) else $error("bad warn");
  chk_main_pull: assert property (
    main_power_good [*8] |-> !main_group_pulldown_en) else $error("pull stuck on");
  chk_main_pull_on: assert property (
    !main_power_good [*8] |-> main_group_pulldown_en) else $error("main pull missing");
  // Eight cycles cover the three-stage filter plus the output register
  chk_stby_pull: assert property (
    standby_resume_reset_n [*8] |-> !stby_group_pulldown_en) else $error("stby pull stuck on");
  chk_stby_pull_on: assert property (
    !standby_resume_reset_n [*8] |-> stby_group_pulldown_en) else $error("stby pull missing");
  // Only a group that has sat out of reset for a while takes writes
  chk_host_write: assert property (
    host_bus_reset_n [*8] ##0 host_wr_host |-> ##2 host_straps == $past(host_wdata_host, 2))
    else $error("host write lost");
  cover property (host_wr_host);
  cover property (host_straps.cfg_port_addr_strap);
  cover property (dual_rail_suspend_warn_sel);
endmodule
bind ssp_strap_sampler ssp_strap_sampler_props ssp_strap_sampler_props_inst (.*);
`default_nettype wire

// file: dv/ssp_strap_board.sv
`timescale 1ns/1ns
`default_nettype none
module ssp_strap_board
  import ssp_pkg::*;
(
  // Resistor choices
  input wire logic hi_port,
  input wire logic hi_clk,
  input wire logic hi_dsw,
  input wire logic hi_cpu,
  // Strap pin levels
  output var ssp_host_s host_pins,
  output var ssp_main_s main_pins,
  output var ssp_stby_s stby_pins
);
  // ----------------------------------------
  // Straps
  // ----------------------------------------
  // Mixed levels so a swapped field shows
  assign host_pins = '{hi_port, ~hi_port, hi_port, ~hi_port};
  assign main_pins = '{hi_clk};
  assign stby_pins = '{1'b0, 1'b0, 1'b0, hi_dsw, hi_cpu};
endmodule
`default_nettype wire

// file: dv/strap_sampling_pin_select_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
  $display("BAD %s exp %0h got %0h", n, e, a); end end
module strap_sampling_pin_select_tb
  import ssp_pkg::*;
;
  logic ref_clk = 0, arst_n = 0, stby_n = 0, mpg = 0, hbr_n = 0, wh = 0, wm = 0, ws = 0;
  logic bp = 0, bc = 0, bd = 0, bu = 0, c48, seg, g53, warn, mpd, spd;
  logic [7:0] ip, dp;
  ssp_host_s wdh = '0, hp, hs;
  ssp_main_s wdm = '0, mp, ms;
  ssp_stby_s wds = '0, sp, ss;
  int mismatches = 0, tests_run = 0;
  always #25 ref_clk = ~ref_clk;
  ssp_strap_board ssp_strap_board_inst (.hi_port(bp), .hi_clk(bc), .hi_dsw(bd),
    .hi_cpu(bu), .host_pins(hp), .main_pins(mp), .stby_pins(sp));
  ssp_strap_sampler ssp_strap_sampler_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .standby_resume_reset_n(stby_n), .main_power_good(mpg), .host_bus_reset_n(hbr_n),
    .host_strap_pins(hp), .main_strap_pins(mp), .stby_strap_pins(sp), .host_wr_host(wh),
    .host_wdata_host(wdh), .host_wr_main(wm), .host_wdata_main(wdm), .host_wr_stby(ws),
    .host_wdata_stby(wds), .host_straps(hs), .main_straps(ms), .stby_straps(ss),
    .cfg_index_port(ip), .cfg_data_port(dp), .clk_is_48m(c48), .seven_seg_display_en(seg),
    .gpio_port5_bit3_sel(g53), .dual_rail_suspend_warn_sel(warn),
    .main_group_pulldown_en(mpd), .stby_group_pulldown_en(spd));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cy(int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask
  task automatic wr(ssp_host_s h, ssp_main_s m, ssp_stby_s s);
    wdh = h;
    wdm = m;
    wds = s;
    {wh, wm, ws} = 3'h7;
    cy(1);
    {wh, wm, ws} = 3'h0;
    cy(3);
  endtask
  // Pins stay put across the pulse, as the sampler needs them steady
  task automatic pulse(int k);
    if (k == 0) hbr_n = 0; else if (k == 1) mpg = 0; else stby_n = 0;
    cy(8);
    if (k == 0) hbr_n = 1; else if (k == 1) mpg = 1; else stby_n = 1;
    cy(10);
  endtask
  task automatic end_sim;
    if (mismatches == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_power_up;
    `CHK("main pull", 1'b1, mpd)
    `CHK("stby pull", 1'b1, spd)
    {bp, bc, bd, bu} = 4'hF;
    cy(6);
    stby_n = 1;
    cy(10);
    `CHK("stby", 5'h03, ss)
    `CHK("warn", 1'b1, warn)
    `CHK("cpu seq", 1'b1, ss.cpu_power_seq_strap)
    `CHK("stby pull", 1'b0, spd)
    mpg = 1;
    cy(10);
    `CHK("48m", 1'b1, c48)
    `CHK("main pull", 1'b0, mpd)
    hbr_n = 1;
    cy(10);
    `CHK("index", CFG_INDEX_HI, ip)
    `CHK("data", CFG_DATA_HI, dp)
    `CHK("seg", 1'b0, seg)
    `CHK("host", 4'hA, hs)
    `CHK("serial c", 1'b0, hs.serial_c_postcode_strap)
  endtask
  task automatic t_hold;
    {bp, bc, bd, bu} = 4'h0;
    cy(10);
    `CHK("host hold", 4'hA, hs)
    `CHK("main hold", 1'b1, ms)
    `CHK("stby hold", 5'h03, ss)
  endtask
  task automatic t_override;
    wr(4'h6, 1'b0, 5'h1C);
    `CHK("host wr", 4'h6, hs)
    `CHK("index wr", CFG_INDEX_LO, ip)
    `CHK("main wr", 1'b0, ms)
    `CHK("stby wr", 5'h1C, ss)
    bc = 1;
    pulse(0);
    `CHK("host back", 4'h5, hs)
    `CHK("seg", 1'b1, seg)
    `CHK("stby kept", 5'h1C, ss)
    pulse(1);
    `CHK("main back", 1'b1, ms)
    pulse(2);
    `CHK("stby back", 5'h00, ss)
    `CHK("gpio sel", 1'b1, g53)
  endtask
  initial begin
    cy(20);
    arst_n = 1;
    cy(3);
    t_power_up;
    t_hold;
    t_override;
    end_sim;
  end
  // About fifteen times the expected run
  initial begin
    #100000;
    mismatches++;
    end_sim;
  end
endmodule
`default_nettype wire
